// file: rtl/ssa_status_alert.sv
// status flags, mask register and alert pin of the sensor
`timescale 1ns/100ps
`default_nettype none
module ssa_status_alert
	import ssa_pkg::*;
(
	input  wire logic        i_ref_clk,         // 100 MHz clock
	input  wire logic        i_resetn,          // power-on reset, active low
	input  wire logic        i_sync_reset,      // soft or general-call reset pulse
	input  wire logic [7:0]  i_reg_addr,        // register pointer
	input  wire logic        i_reg_wr,          // register write strobe
	input  wire logic        i_reg_rd,          // register read strobe
	input  wire logic [15:0] i_reg_wdata,       // write data
	output logic      [15:0] o_reg_rdata,       // read data, one cycle after strobe
	output logic             o_reg_rvalid,      // read data valid pulse
	input  wire logic        i_conv_done,       // both results written, pulse
	input  wire logic [15:0] i_obj_result,      // object temperature register
	input  wire logic [15:0] i_die_result,      // die temperature register
	input  wire logic [15:0] i_obj_hi_limit,    // object high limit register
	input  wire logic [15:0] i_obj_lo_limit,    // object low limit register
	input  wire logic [15:0] i_die_hi_limit,    // die high limit register
	input  wire logic [15:0] i_die_lo_limit,    // die low limit register
	input  wire logic        i_math_invalid,    // math engine error this conversion
	input  wire logic        i_volt_overrange,  // sensor voltage over range
	input  wire logic        i_mem_load_done,   // general load finished, pulse
	input  wire logic        i_mem_check_pass,  // integrity check result
	output logic             o_mem_check_fail,  // mirror for memory access bit 12
	output logic             o_alert_enable,    // shared alert output enable
	output logic             o_track_mode,      // flag behaviour select
	output logic             o_alert_n_o,       // alert pin output level
	output logic             o_alert_n_oe       // alert pin pull-down enable
);
	import ssa_pkg::*;

	// result and limit scaled to a common 14-bit twos complement grid
	function automatic logic signed [13:0] result_val(input logic [15:0] r);
		result_val = $signed(r[15:2]);
	endfunction

	function automatic logic signed [13:0] limit_val(input logic [15:0] l);
		limit_val = $signed({l[15:6], {LIMIT_SHIFT{1'b0}}});
	endfunction

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
		is_addr = (a == b);
	endfunction

	logic        alert_en_q, alert_en_d;
	logic        track_q, track_d;
	logic [6:0]  mask_en_q, mask_en_d;
	logic        conv_done_q, conv_done_d;
	logic        mem_fail_q, mem_fail_d;
	logic        overrange_q, overrange_d;
	logic        summary_q, summary_d;
	logic        eval_q, eval_d;
	logic [15:0] rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;
	logic        alert_oe_q, alert_oe_d;

	logic        stat_rd;
	logic        res_rd;
	logic        cfg_wr;
	logic        mask_wr;
	logic        any_enabled;
	logic [15:0] status_view;
	logic [15:0] mask_view;

	logic [NUM_CELLS-1:0] cell_set;
	logic [NUM_CELLS-1:0] cell_clr;
	logic [NUM_CELLS-1:0] cell_flag;
	logic [6:0]           flags_vis;

	assign stat_rd = i_reg_rd && is_addr(i_reg_addr, ADDR_FLAG_STATUS);
	assign res_rd  = i_reg_rd && (is_addr(i_reg_addr, ADDR_SENSOR_VOLT) || is_addr(i_reg_addr, ADDR_DIE_RESULT)
		|| is_addr(i_reg_addr, ADDR_OBJ_RESULT));
	assign cfg_wr  = i_reg_wr && is_addr(i_reg_addr, ADDR_CONFIG);
	assign mask_wr = i_reg_wr && is_addr(i_reg_addr, ADDR_FLAG_MASK);

	// limit comparisons; the low-side flags also set in tracking mode, where they read zero
	always_comb begin
		cell_set = '0;
		cell_clr = '0;
		cell_set[SSA_CELL_OBJ_HIGH] = result_val(i_obj_result) > limit_val(i_obj_hi_limit);
		cell_clr[SSA_CELL_OBJ_HIGH] = !cell_set[SSA_CELL_OBJ_HIGH];
		cell_set[SSA_CELL_OBJ_LOW]  = result_val(i_obj_result) < limit_val(i_obj_lo_limit);
		cell_clr[SSA_CELL_OBJ_LOW]  = !cell_set[SSA_CELL_OBJ_LOW];
		cell_set[SSA_CELL_DIE_HIGH] = result_val(i_die_result) > limit_val(i_die_hi_limit);
		// tracking clear uses the die low limit, giving hysteresis between the two limits
		cell_clr[SSA_CELL_DIE_HIGH] = result_val(i_die_result) < limit_val(i_die_lo_limit);
		cell_set[SSA_CELL_DIE_LOW]  = result_val(i_die_result) < limit_val(i_die_lo_limit);
		cell_clr[SSA_CELL_DIE_LOW]  = !cell_set[SSA_CELL_DIE_LOW];
		cell_set[SSA_CELL_INVALID]  = i_math_invalid || i_volt_overrange;
		cell_clr[SSA_CELL_INVALID]  = !cell_set[SSA_CELL_INVALID];
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
			ssa_flag_cell u_cell (
				.i_ref_clk  (i_ref_clk),
				.i_resetn   (i_resetn),
				.i_sync_clr (i_sync_reset),
				.i_track    (track_q),
				.i_eval     (i_conv_done),
				.i_set      (cell_set[gi]),
				.i_clr      (cell_clr[gi]),
				.i_rd_clr   (stat_rd),
				.o_flag     (cell_flag[gi])
			);
		end
	endgenerate

	// visible flags in status order 14..8; low flags read zero while tracking
	always_comb begin
		flags_vis    = '0;
		flags_vis[6] = conv_done_q;
		flags_vis[5] = cell_flag[SSA_CELL_OBJ_HIGH];
		flags_vis[4] = cell_flag[SSA_CELL_OBJ_LOW] && !track_q;
		flags_vis[3] = cell_flag[SSA_CELL_DIE_HIGH];
		flags_vis[2] = cell_flag[SSA_CELL_DIE_LOW] && !track_q;
		flags_vis[1] = cell_flag[SSA_CELL_INVALID];
		flags_vis[0] = mem_fail_q;
	end

	// mask view: low-side enables inert and zero while tracking, low byte zero
	always_comb begin
		mask_view = FLAG_MASK_RESET;
		mask_view[MASK_ALERT_EN_BIT] = alert_en_q;
		mask_view[MASK_EN_HI:MASK_EN_LO] = mask_en_q;
		if (track_q) begin
			mask_view[STAT_OBJ_LOW_BIT] = 1'b0;
			mask_view[STAT_DIE_LOW_BIT] = 1'b0;
		end
	end

	assign any_enabled = |(flags_vis & mask_view[MASK_EN_HI:MASK_EN_LO]);

	always_comb begin
		status_view = FLAG_STATUS_RESET;
		status_view[STAT_SUMMARY_BIT] = summary_q;
		status_view[STAT_CONV_DONE_BIT:STAT_MEM_FAIL_BIT] = flags_vis;
		status_view[STAT_OVERRANGE_BIT] = overrange_q;
	end

	always_comb begin
		alert_en_d  = alert_en_q;
		track_d     = track_q;
		mask_en_d   = mask_en_q;
		conv_done_d = conv_done_q;
		mem_fail_d  = mem_fail_q;
		overrange_d = overrange_q;
		summary_d   = summary_q;
		rdata_d     = rdata_q;
		rvalid_d    = i_reg_rd;
		eval_d      = i_conv_done;

		// writes to either location land in the one shared enable bit
		if (mask_wr) begin
			alert_en_d = i_reg_wdata[MASK_ALERT_EN_BIT];
			mask_en_d  = i_reg_wdata[MASK_EN_HI:MASK_EN_LO];
		end
		if (cfg_wr) begin
			alert_en_d = i_reg_wdata[CFG_ALERT_EN_BIT];
			track_d    = i_reg_wdata[CFG_TRACK_MODE_BIT];
		end

		// set beats the read and config-write clears in the same cycle
		if (i_conv_done) begin
			conv_done_d = 1'b1;
		end else if (stat_rd || cfg_wr || res_rd) begin
			conv_done_d = 1'b0;
		end

		if (i_conv_done) begin
			overrange_d = i_volt_overrange;
		end

		if (i_mem_load_done) begin
			mem_fail_d = !i_mem_check_pass;
		end

		// a latched read keeps only the enabled memory flag, which no read clears;
		// a flag set in the read cycle raises the summary again one cycle later
		if (!track_q && stat_rd) begin
			summary_d = flags_vis[0] && mask_view[MASK_EN_LO];
		end else if (any_enabled) begin
			summary_d = 1'b1;
		end else if (track_q && eval_q) begin
			summary_d = 1'b0;
		end

		// read data captured before this cycle's clears take effect
		if (i_reg_rd) begin
			rdata_d = '0;
			if (is_addr(i_reg_addr, ADDR_FLAG_STATUS)) begin
				rdata_d = status_view;
			end else if (is_addr(i_reg_addr, ADDR_FLAG_MASK)) begin
				rdata_d = mask_view;
			end else if (is_addr(i_reg_addr, ADDR_CONFIG)) begin
				rdata_d[CFG_ALERT_EN_BIT]   = alert_en_q;
				rdata_d[CFG_SUMMARY_BIT]    = summary_q;
				rdata_d[CFG_TRACK_MODE_BIT] = track_q;
			end
		end

		if (i_sync_reset) begin
			alert_en_d  = ALERT_EN_RESET;
			track_d     = TRACK_MODE_RESET;
			mask_en_d   = FLAG_MASK_RESET[MASK_EN_HI:MASK_EN_LO];
			conv_done_d = 1'b0;
			overrange_d = 1'b0;
			summary_d   = 1'b0;
			// memory fail is re-evaluated by the load that follows every reset
			if (i_mem_load_done) begin
				mem_fail_d = !i_mem_check_pass;
			end
		end

		// pin follows the registered enable and summary so it never glitches
		alert_oe_d = alert_en_d && summary_d;
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			alert_en_q  <= ALERT_EN_RESET;
			track_q     <= TRACK_MODE_RESET;
			mask_en_q   <= FLAG_MASK_RESET[MASK_EN_HI:MASK_EN_LO];
			conv_done_q <= 1'b0;
			mem_fail_q  <= 1'b0;
			overrange_q <= 1'b0;
			summary_q   <= 1'b0;
			rdata_q     <= 16'h0000;
			rvalid_q    <= 1'b0;
			eval_q      <= 1'b0;
			alert_oe_q  <= 1'b0;
		end else begin
			alert_en_q  <= alert_en_d;
			track_q     <= track_d;
			mask_en_q   <= mask_en_d;
			conv_done_q <= conv_done_d;
			mem_fail_q  <= mem_fail_d;
			overrange_q <= overrange_d;
			summary_q   <= summary_d;
			rdata_q     <= rdata_d;
			rvalid_q    <= rvalid_d;
			eval_q      <= eval_d;
			alert_oe_q  <= alert_oe_d;
		end
	end

	assign o_reg_rdata      = rdata_q;
	assign o_reg_rvalid     = rvalid_q;
	assign o_mem_check_fail = mem_fail_q;
	assign o_alert_enable   = alert_en_q;
	assign o_track_mode     = track_q;
	assign o_alert_n_o      = 1'b0;        // open drain: only ever pulls low
	assign o_alert_n_oe     = alert_oe_q;
endmodule
`default_nettype wire

// file: common/ssa_pkg.sv
// constants shared by the sensor status and alert block
package ssa_pkg;
	// register offsets on the internal register port
	localparam logic [7:0] ADDR_SENSOR_VOLT  = 8'h00;
	localparam logic [7:0] ADDR_DIE_RESULT   = 8'h01;
	localparam logic [7:0] ADDR_CONFIG       = 8'h02;
	localparam logic [7:0] ADDR_OBJ_RESULT   = 8'h03;
	localparam logic [7:0] ADDR_FLAG_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_FLAG_MASK    = 8'h05;

	// flag_status field positions
	localparam int STAT_SUMMARY_BIT     = 15;
	localparam int STAT_CONV_DONE_BIT   = 14;
	localparam int STAT_OBJ_HIGH_BIT    = 13;
	localparam int STAT_OBJ_LOW_BIT     = 12;
	localparam int STAT_DIE_HIGH_BIT    = 11;
	localparam int STAT_DIE_LOW_BIT     = 10;
	localparam int STAT_INVALID_BIT     = 9;
	localparam int STAT_MEM_FAIL_BIT    = 8;
	localparam int STAT_OVERRANGE_BIT   = 7;

	// flag_mask_enable field positions; bits 14..8 line up with the status flags
	localparam int MASK_ALERT_EN_BIT    = 15;
	localparam int MASK_EN_HI           = 14;
	localparam int MASK_EN_LO           = 8;

	// configuration bits owned by this block
	localparam int CFG_ALERT_EN_BIT     = 8;
	localparam int CFG_SUMMARY_BIT      = 7;
	localparam int CFG_TRACK_MODE_BIT   = 5;

	// reset values
	localparam logic [15:0] FLAG_MASK_RESET   = 16'h0000;
	localparam logic [15:0] FLAG_STATUS_RESET = 16'h0000;
	localparam logic        ALERT_EN_RESET    = 1'b0;
	localparam logic        TRACK_MODE_RESET  = 1'b0;

	// limit registers keep 10 bits at 0.5 degC, results 14 bits at 1/32 degC
	localparam int LIMIT_SHIFT = 4;

	// limit and invalid flags handled by generic flag cells
	typedef enum logic [2:0] {
		SSA_CELL_OBJ_HIGH,
		SSA_CELL_OBJ_LOW,
		SSA_CELL_DIE_HIGH,
		SSA_CELL_DIE_LOW,
		SSA_CELL_INVALID
	} ssa_cell_t;
	localparam int NUM_CELLS = 5;
endpackage

// file: rtl/ssa_flag_cell.sv
// one status flag that either latches until read or tracks each conversion
`timescale 1ns/100ps
`default_nettype none
module ssa_flag_cell (
	input  wire logic i_ref_clk,   // system clock
	input  wire logic i_resetn,    // async reset, active low
	input  wire logic i_sync_clr,  // soft or general-call reset
	input  wire logic i_track,     // 1 = tracking mode
	input  wire logic i_eval,      // end of conversion pulse
	input  wire logic i_set,       // condition violated this conversion
	input  wire logic i_clr,       // tracking-mode clear condition
	input  wire logic i_rd_clr,    // status read pulse
	output logic      o_flag       // flag value
);
	logic flag_q;
	logic flag_d;

	always_comb begin
		flag_d = flag_q;
		if (i_sync_clr) begin
			flag_d = 1'b0;
		end else if (i_track) begin
			if (i_eval && i_set) begin
				flag_d = 1'b1;
			end else if (i_eval && i_clr) begin
				flag_d = 1'b0;
			end
		end else begin
			// a new violation beats the read clear so the event is not lost
			if (i_eval && i_set) begin
				flag_d = 1'b1;
			end else if (i_rd_clr) begin
				flag_d = 1'b0;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign o_flag = flag_q;
endmodule
`default_nettype wire

// file: dv/ssa_status_alert_asserts.sv
// port-level checks for the status and alert block
`timescale 1ns/100ps
`default_nettype none
module ssa_status_alert_chk
	import ssa_pkg::*;
(
	input wire logic        i_ref_clk,        // clock
	input wire logic        i_resetn,         // reset, active low
	input wire logic        i_sync_reset,     // soft reset
	input wire logic [7:0]  i_reg_addr,       // pointer
	input wire logic        i_reg_wr,         // write strobe
	input wire logic        i_reg_rd,         // read strobe
	input wire logic [15:0] i_reg_wdata,      // write data
	input wire logic [15:0] o_reg_rdata,      // read data
	input wire logic        o_reg_rvalid,     // read valid
	input wire logic        i_mem_load_done,  // load end
	input wire logic        i_mem_check_pass, // check result
	input wire logic        o_mem_check_fail, // memory fail
	input wire logic        o_alert_enable,   // alert enable
	input wire logic        o_track_mode,     // flag mode
	input wire logic        o_alert_n_o,      // pin level
	input wire logic        o_alert_n_oe      // pin enable
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	// read data is judged against the register that was addressed
	logic [7:0] ra_q;
	always_ff @(posedge i_ref_clk) begin
		if (i_reg_rd)
			ra_q <= i_reg_addr;
	end
	wire logic rd_st = o_reg_rvalid && ra_q == ADDR_FLAG_STATUS;
	wire logic rd_mk = o_reg_rvalid && ra_q == ADDR_FLAG_MASK;
	wire logic wr_ok = i_reg_wr && !i_sync_reset;
	property p_rvalid; i_reg_rd |=> o_reg_rvalid; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_st_low; rd_st |-> o_reg_rdata[6:0] == 7'h00; endproperty
	a_st_low: assert property (p_st_low) else $error("status low bits set");
	property p_mk_low; rd_mk |-> o_reg_rdata[7:0] == 8'h00; endproperty
	a_mk_low: assert property (p_mk_low) else $error("mask low byte set");
	property p_trk; (rd_st || rd_mk) && $past(o_track_mode) |-> !o_reg_rdata[12] && !o_reg_rdata[10]; endproperty
	a_trk: assert property (p_trk) else $error("low bits live in tracking");
	property p_mirror; rd_mk |-> o_reg_rdata[15] == $past(o_alert_enable); endproperty
	a_mirror: assert property (p_mirror) else $error("mask enable mismatch");
	property p_wr_mk; wr_ok && i_reg_addr == ADDR_FLAG_MASK |=> o_alert_enable == $past(i_reg_wdata[15]); endproperty
	a_wr_mk: assert property (p_wr_mk) else $error("mask write lost");
	property p_wr_cfg;
		wr_ok && i_reg_addr == ADDR_CONFIG |=> o_alert_enable == $past(i_reg_wdata[8]) && o_track_mode == $past(i_reg_wdata[5]);
	endproperty
	a_wr_cfg: assert property (p_wr_cfg) else $error("config write lost");
	property p_pin_off; !o_alert_enable ##1 !o_alert_enable |-> !o_alert_n_oe; endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin driven while off");
	property p_pin_lvl; o_alert_n_oe |-> o_alert_n_o == 1'b0; endproperty
	a_pin_lvl: assert property (p_pin_lvl) else $error("pin not low");
	property p_mem; i_mem_load_done |=> o_mem_check_fail == !$past(i_mem_check_pass); endproperty
	a_mem: assert property (p_mem) else $error("memory flag wrong");
	property p_mem_hold; !i_mem_load_done |=> $stable(o_mem_check_fail); endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory flag moved");
	c_stat: cover property (i_reg_rd && i_reg_addr == ADDR_FLAG_STATUS);
	c_pin: cover property (o_alert_n_oe);
	c_fail: cover property (i_mem_load_done && !i_mem_check_pass);
endmodule
`default_nettype wire

// file: dv/ssa_host.sv
// register-port host model: one-cycle strobes, read waits for valid
`timescale 1ns/100ps
`default_nettype none
module ssa_host (
	input  wire logic        i_ref_clk, // clock
	input  wire logic [15:0] i_rdata,   // read data
	input  wire logic        i_rvalid,  // read valid
	output logic      [7:0]  o_addr,    // pointer
	output logic             o_wr,      // write strobe
	output logic             o_rd,      // read strobe
	output logic      [15:0] o_wdata    // write data
);
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 16'h0000;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_ref_clk);
		o_wr <= 1'b0;
	endtask
	// bounded wait: a missing answer returns unknowns, which never compare equal
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_ref_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_ref_clk);
		o_rd <= 1'b0;
		d = 'x;
		repeat (4) begin
			@(posedge i_ref_clk);
			if (i_rvalid === 1'b1) begin
				d = i_rdata;
				break;
			end
		end
	endtask
endmodule
`default_nettype wire

// file: dv/tb_ssa_status_alert.sv
// self-checking bench for the status and alert block
`timescale 1ns/100ps
`default_nettype none
module tb_ssa_status_alert;
	import ssa_pkg::*;
	// results and limits both scale to degC*128, so limits are 50 and 10 degC
	localparam logic [15:0] HOT = 16'h1E00;
	localparam logic [15:0] MID = 16'h0F00;
	localparam logic [15:0] COLD = 16'h0000;
	logic        i_ref_clk, i_resetn, i_sync_reset, i_reg_wr, i_reg_rd, i_conv_done;
	logic        i_math_invalid, i_volt_overrange, i_mem_load_done, i_mem_check_pass;
	logic        o_reg_rvalid, o_mem_check_fail, o_alert_enable, o_track_mode, o_alert_n_o, o_alert_n_oe;
	logic [7:0]  i_reg_addr;
	logic [15:0] i_reg_wdata, o_reg_rdata, i_obj_result, i_die_result, r;
	int          n_mismatch = 0;
	int          check_count = 0;
	ssa_status_alert dut (.i_ref_clk, .i_resetn, .i_sync_reset, .i_reg_addr, .i_reg_wr, .i_reg_rd,
		.i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_conv_done, .i_obj_result, .i_die_result,
		.i_obj_hi_limit(16'h1900), .i_obj_lo_limit(16'h0500), .i_die_hi_limit(16'h1900),
		.i_die_lo_limit(16'h0500), .i_math_invalid, .i_volt_overrange, .i_mem_load_done,
		.i_mem_check_pass, .o_mem_check_fail, .o_alert_enable, .o_track_mode, .o_alert_n_o, .o_alert_n_oe);
	ssa_host host (.i_ref_clk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid), .o_addr(i_reg_addr),
		.o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata));
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic rs(input logic [7:0] a, input logic [15:0] e);
		host.rd(a, r);
		chk(r, e);
	endtask
	task automatic cv(input logic [15:0] o, input logic [15:0] d, input logic iv, input logic ov);
		@(posedge i_ref_clk);
		i_obj_result <= o;
		i_die_result <= d;
		i_math_invalid <= iv;
		i_volt_overrange <= ov;
		i_conv_done <= 1'b1;
		@(posedge i_ref_clk);
		i_conv_done <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic ld(input logic p);
		@(posedge i_ref_clk);
		i_mem_load_done <= 1'b1;
		i_mem_check_pass <= p;
		@(posedge i_ref_clk);
		i_mem_load_done <= 1'b0;
		#1;
		chk({15'h0000, o_mem_check_fail}, {15'h0000, ~p});
	endtask
	task automatic t_reset();
		rs(ADDR_FLAG_MASK, 16'h0000);
		rs(8'h1F, 16'h0000);
		host.wr(ADDR_FLAG_STATUS, 16'hFFFF);
		rs(ADDR_FLAG_STATUS, 16'h0000);
	endtask
	task automatic t_latch();
		host.wr(ADDR_FLAG_MASK, 16'hFFFF);
		rs(ADDR_FLAG_MASK, 16'hFF00);
		cv(HOT, COLD, 1'b0, 1'b0);
		chk({15'h0000, o_alert_n_oe}, 16'h0001);
		cv(MID, MID, 1'b0, 1'b0);
		rs(ADDR_FLAG_STATUS, 16'hE400);
		rs(ADDR_FLAG_STATUS, 16'h0000);
		chk({15'h0000, o_alert_n_oe}, 16'h0000);
		cv(MID, MID, 1'b1, 1'b1);
		rs(ADDR_FLAG_STATUS, 16'hC280);
		rs(ADDR_FLAG_STATUS, 16'h0080);
		host.wr(ADDR_FLAG_MASK, 16'h8000);
		cv(MID, MID, 1'b0, 1'b0);
		host.rd(ADDR_OBJ_RESULT, r);
		rs(ADDR_FLAG_STATUS, 16'h0000);
		cv(MID, MID, 1'b0, 1'b0);
		host.wr(ADDR_CONFIG, 16'h0000);
		rs(ADDR_FLAG_STATUS, 16'h0000);
		cv(MID, MID, 1'b0, 1'b0);
		rs(ADDR_FLAG_STATUS, 16'h4000);
	endtask
	task automatic t_track();
		host.wr(ADDR_CONFIG, 16'h0020);
		host.wr(ADDR_FLAG_MASK, 16'hBF00);
		rs(ADDR_FLAG_MASK, 16'hAB00);
		rs(ADDR_CONFIG, 16'h0120);
		cv(COLD, HOT, 1'b0, 1'b0);
		chk({15'h0000, o_alert_n_oe}, 16'h0001);
		rs(ADDR_FLAG_STATUS, 16'hC800);
		cv(MID, MID, 1'b0, 1'b0);
		rs(ADDR_FLAG_STATUS, 16'hC800);
		cv(MID, COLD, 1'b0, 1'b0);
		rs(ADDR_FLAG_STATUS, 16'h4000);
		cv(MID, MID, 1'b1, 1'b0);
		rs(ADDR_FLAG_STATUS, 16'hC200);
		cv(MID, MID, 1'b0, 1'b0);
		rs(ADDR_FLAG_STATUS, 16'h4000);
	endtask
	task automatic t_mem();
		ld(1'b0);
		@(posedge i_ref_clk);
		i_sync_reset <= 1'b1;
		@(posedge i_ref_clk);
		i_sync_reset <= 1'b0;
		rs(ADDR_FLAG_STATUS, 16'h0100);
		rs(ADDR_FLAG_MASK, 16'h0000);
		ld(1'b1);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		i_resetn = 1'b0;
		i_sync_reset = 1'b0;
		i_conv_done = 1'b0;
		i_obj_result = 16'h0000;
		i_die_result = 16'h0000;
		i_math_invalid = 1'b0;
		i_volt_overrange = 1'b0;
		i_mem_load_done = 1'b0;
		i_mem_check_pass = 1'b1;
		repeat (20) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		t_reset();
		t_latch();
		t_track();
		t_mem();
		final_report();
	end
	// the sequence needs well under 500 cycles; 3000 leaves room without hiding a hang
	initial begin
		repeat (3000) @(posedge i_ref_clk);
		n_mismatch++;
		final_report();
	end
endmodule
bind ssa_status_alert ssa_status_alert_chk u_chk (.i_ref_clk, .i_resetn, .i_sync_reset, .i_reg_addr,
	.i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_mem_load_done, .i_mem_check_pass,
	.o_mem_check_fail, .o_alert_enable, .o_track_mode, .o_alert_n_o, .o_alert_n_oe);
`default_nettype wire
